// [hdl/i2crs_fifo.sv]
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps

module i2crs_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             ref_clk_i,
    input  wire logic             rst_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic             push;
    logic             pop;

    assign in_ready_o  = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
    assign out_valid_o = (wr_ptr != rd_ptr);
    assign out_data_o  = mem[rd_ptr[AW-1:0]];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_ff @(posedge ref_clk_i) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
        end else if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            rd_ptr <= '0;
        end else if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
        end
    end

endmodule

// [hdl/i2crs_line_filter.sv]
// Two-flop synchronisers and glitch filters for the bus lines
`timescale 1ns/100ps
`include "i2crs_params.svh"

module i2crs_line_filter #(
    parameter int LINES = 2
) (
    input  wire logic             ref_clk_i,
    input  wire logic             rst_i,
    input  wire logic [LINES-1:0] line_i,
    output logic      [LINES-1:0] line_o
);

    genvar g;
    generate
        for (g = 0; g < LINES; g++) begin : g_line
            logic                         meta;
            logic                         sync;
            logic [`I2CRS_FILT_CNT_W-1:0] cnt;
            logic                         filt;

            assign line_o[g] = filt;

            // Idle bus is high, so reset to high to avoid a false start
            always_ff @(posedge ref_clk_i) begin
                if (rst_i) begin
                    meta <= 1'b1;
                    sync <= 1'b1;
                end else begin
                    meta <= line_i[g];
                    sync <= meta;
                end
            end

            // Output follows only after the new level has held for the full window
            always_ff @(posedge ref_clk_i) begin
                if (rst_i) begin
                    cnt  <= '0;
                    filt <= 1'b1;
                end else if (sync == filt) begin
                    cnt <= '0;
                end else if (cnt == `I2CRS_FILT_CNT_W'(`I2CRS_FILT_CYC - 1)) begin
                    cnt  <= '0;
                    filt <= sync;
                end else begin
                    cnt <= cnt + 1'b1;
                end
            end
        end
    endgenerate

endmodule

// [hdl/i2crs_params.svh]
// Constants for the two-wire register slave: address, widths and timing counts
`ifndef I2CRS_PARAMS_SVH
`define I2CRS_PARAMS_SVH

`define I2CRS_SLAVE_ADDR     7'h3e
`define I2CRS_BYTE_BITS      4'h8
`define I2CRS_LAST_TX_BIT    4'h7
`define I2CRS_PTR_W          8
`define I2CRS_DATA_W         8
`define I2CRS_FIFO_W         16
`define I2CRS_FIFO_DEPTH     8
`define I2CRS_MAX_SCL_KHZ    400
`define I2CRS_CLK_PERIOD_NS  4
`define I2CRS_DEGLITCH_NS    50
// Least time, so the division rounds up
`define I2CRS_FILT_CYC       ((`I2CRS_DEGLITCH_NS + `I2CRS_CLK_PERIOD_NS - 1) / `I2CRS_CLK_PERIOD_NS)
`define I2CRS_FILT_CNT_W     4

`endif

// [hdl/i2crs_pkg.sv]
// Types shared by the two-wire register slave
package i2crs_pkg;

    typedef enum logic [5:0] {
        ST_IDLE    = 6'h01,
        ST_RX      = 6'h02,
        ST_ACK_OUT = 6'h04,
        ST_TX      = 6'h08,
        ST_ACK_IN  = 6'h10,
        ST_WAIT    = 6'h20
    } i2crs_state_t;

    typedef enum logic [1:0] {
        KIND_ADDR = 2'h0,
        KIND_PTR  = 2'h1,
        KIND_DATA = 2'h2
    } i2crs_kind_t;

endpackage

// [hdl/i2crs_slave.sv]
// Two-wire register slave: bus protocol engine, pointer and write queue
`timescale 1ns/100ps
`include "i2crs_params.svh"

////////////////////////////////////////////////////////////////////////////////
// What this block does
// - Respond only to address 0111110
// - Direction bit: 0 write, 1 read
// - Start: data falls while clock high
// - Stop: data rises while clock high
// - Data stable in clock high, sampled there
// - Data change in clock high aborts transfer
// - Bytes are eight bits, MSB first, then ack
// - Acknowledge by pulling data low
// - Acknowledge address only when it matches
// - First write byte is the register pointer
// - Later write bytes stored at pointer and acknowledged while the queue has room
// - Pointer steps by one per written byte
// - Read sends register at current pointer
// - After read byte, release and sample ack
// - Master ack: pointer steps, next byte sent
// - Master nack: release and await stop
module i2crs_slave (
    input  wire logic                     ref_clk_i,
    input  wire logic                     rst_i,
    input  wire logic                     scl_i,
    input  wire logic                     sda_i,
    output logic                          sda_o,
    output logic                          sda_oe_n_o,
    output logic      [`I2CRS_PTR_W-1:0]  rd_addr_o,
    output logic                          rd_strobe_o,
    input  wire logic [`I2CRS_DATA_W-1:0] rd_data_i,
    output logic                          wr_valid_o,
    input  wire logic                     wr_ready_i,
    output logic      [`I2CRS_PTR_W-1:0]  wr_addr_o,
    output logic      [`I2CRS_DATA_W-1:0] wr_data_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Line conditioning and bus events

    logic [1:0]                  lines_f;
    logic                        scl_f;
    logic                        sda_f;
    logic                        scl_d;
    logic                        sda_d;
    logic                        scl_rise;
    logic                        scl_fall;
    logic                        start_det;
    logic                        stop_det;

    i2crs_pkg::i2crs_state_t     state;
    i2crs_pkg::i2crs_kind_t      kind;
    logic [3:0]                  bit_cnt;
    logic [`I2CRS_DATA_W-1:0]    rx_shift;
    logic [`I2CRS_DATA_W-1:0]    tx_shift;
    logic [`I2CRS_PTR_W-1:0]     ptr;
    logic                        read_dir;
    logic                        master_ack;
    logic                        drive_low;
    logic                        byte_done;
    logic                        accept;
    logic                        load_tx;
    logic                        fifo_in_valid;
    logic                        fifo_in_ready;

    i2crs_line_filter #(
        .LINES (2)
    ) u_filter (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .line_i    ({scl_i, sda_i}),
        .line_o    (lines_f)
    );

    assign scl_f = lines_f[1];
    assign sda_f = lines_f[0];

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_f;
            sda_d <= sda_f;
        end
    end

    assign scl_rise  = scl_f && !scl_d;
    assign scl_fall  = !scl_f && scl_d;
    // Both lines pass identical delays, so their relative timing is kept
    assign start_det = scl_f && scl_d && sda_d && !sda_f;
    assign stop_det  = scl_f && scl_d && !sda_d && sda_f;

    ////////////////////////////////////////////////////////////////////////////
    // Byte acceptance

    function automatic logic byte_accepted(input i2crs_pkg::i2crs_kind_t k,
                                           input logic [7:0]             b,
                                           input logic                   room);
        case (k)
            i2crs_pkg::KIND_ADDR: byte_accepted = (b[7:1] == `I2CRS_SLAVE_ADDR);
            i2crs_pkg::KIND_PTR:  byte_accepted = 1'b1;
            i2crs_pkg::KIND_DATA: byte_accepted = room;
            default:              byte_accepted = 1'b0;
        endcase
    endfunction

    assign byte_done = (state == i2crs_pkg::ST_RX) && scl_fall
                       && (bit_cnt == `I2CRS_BYTE_BITS);
    assign accept    = byte_accepted(kind, rx_shift, fifo_in_ready);
    // A full queue refuses the byte with a nack rather than losing it
    assign fifo_in_valid = byte_done && (kind == i2crs_pkg::KIND_DATA) && fifo_in_ready;

    // Next read byte is fetched after the address ack or after a master ack
    assign load_tx = scl_fall
                     && (((state == i2crs_pkg::ST_ACK_OUT)
                          && (kind == i2crs_pkg::KIND_ADDR) && read_dir)
                         || ((state == i2crs_pkg::ST_ACK_IN) && master_ack));

    ////////////////////////////////////////////////////////////////////////////
    // Protocol state

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state <= i2crs_pkg::ST_IDLE;
        end else if (start_det) begin
            state <= i2crs_pkg::ST_RX;
        end else if (stop_det) begin
            state <= i2crs_pkg::ST_IDLE;
        end else begin
            case (state)
                i2crs_pkg::ST_IDLE: begin
                    state <= i2crs_pkg::ST_IDLE;
                end
                i2crs_pkg::ST_RX: begin
                    if (byte_done) begin
                        state <= accept ? i2crs_pkg::ST_ACK_OUT : i2crs_pkg::ST_WAIT;
                    end
                end
                i2crs_pkg::ST_ACK_OUT: begin
                    if (scl_fall) begin
                        state <= load_tx ? i2crs_pkg::ST_TX : i2crs_pkg::ST_RX;
                    end
                end
                i2crs_pkg::ST_TX: begin
                    if (scl_fall && (bit_cnt == `I2CRS_LAST_TX_BIT)) begin
                        state <= i2crs_pkg::ST_ACK_IN;
                    end
                end
                i2crs_pkg::ST_ACK_IN: begin
                    if (scl_fall) begin
                        state <= master_ack ? i2crs_pkg::ST_TX : i2crs_pkg::ST_WAIT;
                    end
                end
                i2crs_pkg::ST_WAIT: begin
                    state <= i2crs_pkg::ST_WAIT;
                end
                default: begin
                    state <= i2crs_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i || start_det) begin
            kind <= i2crs_pkg::KIND_ADDR;
        end else if ((state == i2crs_pkg::ST_ACK_OUT) && scl_fall) begin
            case (kind)
                i2crs_pkg::KIND_ADDR: kind <= i2crs_pkg::KIND_PTR;
                default:              kind <= i2crs_pkg::KIND_DATA;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i || start_det) begin
            read_dir <= 1'b0;
        end else if (byte_done && (kind == i2crs_pkg::KIND_ADDR)) begin
            read_dir <= rx_shift[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bit counter and shift registers

    always_ff @(posedge ref_clk_i) begin
        if (rst_i || start_det || stop_det) begin
            bit_cnt <= '0;
        end else if (load_tx || ((state == i2crs_pkg::ST_ACK_OUT) && scl_fall)) begin
            bit_cnt <= '0;
        end else if ((state == i2crs_pkg::ST_RX) && scl_rise) begin
            bit_cnt <= bit_cnt + 1'b1;
        end else if ((state == i2crs_pkg::ST_TX) && scl_fall) begin
            bit_cnt <= bit_cnt + 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            rx_shift <= '0;
        end else if ((state == i2crs_pkg::ST_RX) && scl_rise) begin
            rx_shift <= {rx_shift[6:0], sda_f};
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            tx_shift <= '0;
        end else if (load_tx) begin
            tx_shift <= rd_data_i;
        end else if ((state == i2crs_pkg::ST_TX) && scl_fall) begin
            tx_shift <= {tx_shift[6:0], 1'b0};
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i || start_det) begin
            master_ack <= 1'b0;
        end else if ((state == i2crs_pkg::ST_ACK_IN) && scl_rise) begin
            master_ack <= !sda_f;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register pointer

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ptr <= '0;
        end else if (byte_done && (kind == i2crs_pkg::KIND_PTR)) begin
            ptr <= rx_shift;
        end else if (fifo_in_valid) begin
            ptr <= ptr + 1'b1;
        end else if ((state == i2crs_pkg::ST_ACK_IN) && scl_rise && !sda_f) begin
            ptr <= ptr + 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            rd_strobe_o <= 1'b0;
        end else begin
            rd_strobe_o <= load_tx;
        end
    end

    assign rd_addr_o = ptr;

    ////////////////////////////////////////////////////////////////////////////
    // Data line drive; changes only follow a clock fall

    always_ff @(posedge ref_clk_i) begin
        if (rst_i || start_det || stop_det) begin
            drive_low <= 1'b0;
        end else if (byte_done) begin
            drive_low <= accept;
        end else if (load_tx) begin
            drive_low <= !rd_data_i[7];
        end else if ((state == i2crs_pkg::ST_TX) && scl_fall) begin
            drive_low <= (bit_cnt == `I2CRS_LAST_TX_BIT) ? 1'b0 : !tx_shift[6];
        end else if (scl_fall) begin
            drive_low <= 1'b0;
        end
    end

    // Open drain: the pin is only ever pulled low
    assign sda_o      = 1'b0;
    assign sda_oe_n_o = !drive_low;

    ////////////////////////////////////////////////////////////////////////////
    // Write queue towards the register file

    i2crs_fifo #(
        .WIDTH (`I2CRS_FIFO_W),
        .DEPTH (`I2CRS_FIFO_DEPTH)
    ) u_wr_fifo (
        .ref_clk_i   (ref_clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (fifo_in_valid),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   ({ptr, rx_shift}),
        .out_valid_o (wr_valid_o),
        .out_ready_i (wr_ready_i),
        .out_data_o  ({wr_addr_o, wr_data_o})
    );

endmodule

// [tb/i2c_register_slave_tb_top.sv]
// Self-checking bench for the two-wire register slave
`timescale 1ns/100ps

module i2c_register_slave_tb_top;
    logic       ref_clk_i = 1'b0;
    logic       rst_i = 1'b1;
    logic       wr_ready_i = 1'b0;
    logic       scl, m_sda, sda_line, sda_o, sda_oe_n_o, rd_strobe_o, wr_valid_o;
    logic [7:0] rd_addr_o, rd_data_i, wr_addr_o, wr_data_o;
    logic [7:0] regs [256];
    int         err_total = 0;
    int         n_checks = 0;

    i2crs_slave i2crs_slave_inst (.ref_clk_i, .rst_i, .scl_i(scl), .sda_i(sda_line), .sda_o,
        .sda_oe_n_o, .rd_addr_o, .rd_strobe_o, .rd_data_i, .wr_valid_o, .wr_ready_i,
        .wr_addr_o, .wr_data_o);
    i2crs_master_model i2crs_master_model_inst (.sda_i(sda_line), .scl_o(scl), .sda_o(m_sda));

    // Wired-and with pull-up: low when either party pulls
    assign sda_line = m_sda & (sda_oe_n_o | sda_o);
    assign rd_data_i = regs[rd_addr_o];

    always #2 ref_clk_i = ~ref_clk_i;

    always @(posedge ref_clk_i) begin
        if (wr_valid_o === 1'b1 && wr_ready_i) begin
            regs[wr_addr_o] <= wr_data_o;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_byte({7'h00, got}, {7'h00, exp});
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic put(input logic [7:0] b, input logic exp_ack);
        logic a;
        i2crs_master_model_inst.send_byte(b, a);
        chk_bit(a, exp_ack);
    endtask

    task automatic rd(input logic ack, input logic [7:0] exp);
        logic [7:0] b;
        i2crs_master_model_inst.recv_byte(ack, b);
        chk_byte(b, exp);
    endtask

    task automatic set_ptr(input logic [7:0] p);
        i2crs_master_model_inst.start();
        put(8'h7c, 1'b1);
        put(p, 1'b1);
    endtask

    task automatic drain();
        for (int i = 0; i < 200 && wr_valid_o !== 1'b0; i++) @(posedge ref_clk_i);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic test_write();
        @(posedge ref_clk_i) wr_ready_i <= 1'b1;
        set_ptr(8'h05);
        put(8'ha5, 1'b1);
        put(8'h3c, 1'b1);
        i2crs_master_model_inst.stop();
        drain();
        chk_byte(rd_addr_o, 8'h07);
        chk_byte(regs[8'h05], 8'ha5);
        chk_byte(regs[8'h06], 8'h3c);
    endtask

    task automatic test_read();
        set_ptr(8'h05);
        i2crs_master_model_inst.start();
        put(8'h7d, 1'b1);
        rd(1'b1, 8'ha5);
        rd(1'b0, 8'h3c);
        // Device answers about 16 cycles after a clock fall
        repeat (30) @(posedge ref_clk_i);
        chk_bit(sda_oe_n_o, 1'b1);
        chk_byte(rd_addr_o, 8'h06);
        i2crs_master_model_inst.stop();
    endtask

    task automatic test_foreign();
        logic [7:0] bad [4] = '{8'h7e, 8'h3c, 8'hfc, 8'h7b};
        for (int i = 0; i < 4; i++) begin
            i2crs_master_model_inst.start();
            put(bad[i], 1'b0);
            put(8'h00, 1'b0);
            i2crs_master_model_inst.stop();
        end
        chk_byte(rd_addr_o, 8'h06);
    endtask

    task automatic test_abort();
        logic s;
        set_ptr(8'h20);
        repeat (3) i2crs_master_model_inst.bit_slot(1'b0, s);
        i2crs_master_model_inst.start();
        put(8'h7d, 1'b1);
        rd(1'b0, 8'h7a);
        chk_byte(rd_addr_o, 8'h20);
        i2crs_master_model_inst.stop();
    endtask

    task automatic test_fifo_full();
        @(posedge ref_clk_i) wr_ready_i <= 1'b0;
        set_ptr(8'h40);
        for (int i = 0; i < 8; i++) put(8'h80 + 8'(i), 1'b1);
        put(8'hee, 1'b0);
        chk_bit(wr_valid_o, 1'b1);
        i2crs_master_model_inst.stop();
        @(posedge ref_clk_i) wr_ready_i <= 1'b1;
        drain();
        chk_bit(wr_valid_o, 1'b0);
        for (int i = 0; i < 8; i++) chk_byte(regs[8'h40 + 8'(i)], 8'h80 + 8'(i));
        chk_byte(regs[8'h48], 8'h12);
        chk_byte(rd_addr_o, 8'h48);
    endtask

    initial begin
        for (int i = 0; i < 256; i++) regs[i] = 8'(i) ^ 8'h5a;
        repeat (6) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        repeat (20) @(posedge ref_clk_i);
        chk_bit(sda_oe_n_o, 1'b1);
        chk_byte(rd_addr_o, 8'h00);
        test_write();
        test_read();
        test_foreign();
        test_abort();
        test_fifo_full();
        final_report();
    end

    // Whole sequence needs roughly 50 us of bus time
    initial begin
        #200000;
        err_total++;
        final_report();
    end
endmodule

// [tb/i2crs_master_model.sv]
// Behavioural bus master with a 160 ns bit period
`timescale 1ns/100ps

module i2crs_master_model (
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_o
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    // One slot from clock fall to fall; data moves only in the low phase
    task automatic bit_slot(input logic v, output logic s);
        #20 sda_o = v;
        #60 scl_o = 1'b1;
        #40 s = sda_i;
        #40 scl_o = 1'b0;
    endtask

    task automatic start();
        if (scl_o === 1'b0) begin
            #20 sda_o = 1'b1;
            #60 scl_o = 1'b1;
        end
        #80 sda_o = 1'b0;
        #80 scl_o = 1'b0;
    endtask

    task automatic stop();
        #20 sda_o = 1'b0;
        #60 scl_o = 1'b1;
        #80 sda_o = 1'b1;
        #80;
    endtask

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_slot(b[i], s);
        bit_slot(1'b1, s);
        ack = ~s;
    endtask

    task automatic recv_byte(input logic ack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) bit_slot(1'b1, b[i]);
        bit_slot(~ack, s);
    endtask
endmodule

// [tb/i2crs_slave_properties.sv]
// Port-level checks for the two-wire register slave
`timescale 1ns/100ps
`include "i2crs_params.svh"

module i2crs_slave_properties (
    input wire logic                     ref_clk_i,
    input wire logic                     rst_i,
    input wire logic                     scl_i,
    input wire logic                     sda_i,
    input wire logic                     sda_o,
    input wire logic                     sda_oe_n_o,
    input wire logic [`I2CRS_PTR_W-1:0]  rd_addr_o,
    input wire logic                     rd_strobe_o,
    input wire logic [`I2CRS_DATA_W-1:0] rd_data_i,
    input wire logic                     wr_valid_o,
    input wire logic                     wr_ready_i,
    input wire logic [`I2CRS_PTR_W-1:0]  wr_addr_o,
    input wire logic [`I2CRS_DATA_W-1:0] wr_data_o
);
    // Read data of the previous cycle, the byte loaded just before the strobe
    logic [`I2CRS_DATA_W-1:0] data_q;

    always_ff @(posedge ref_clk_i) begin
        data_q <= rd_data_i;
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    ////////////////////////////////////////////////////////////////////////////
    chk_sda_open_drain: assert property (sda_o == 1'b0)
        else $error("data pin value is not low");
    chk_reset_idle: assert property ($fell(rst_i) |-> sda_oe_n_o && !rd_strobe_o &&
        !wr_valid_o && rd_addr_o == 8'h00) else $error("outputs not idle after reset");
    chk_drive_scl_low: assert property ($changed(sda_oe_n_o) |-> !scl_i)
        else $error("data drive changed while clock high");
    chk_strobe_pulse: assert property (rd_strobe_o |=> !rd_strobe_o)
        else $error("read strobe longer than one cycle");
    chk_strobe_scl_low: assert property (rd_strobe_o |-> !scl_i)
        else $error("read byte loaded while clock high");
    chk_read_msb: assert property (rd_strobe_o |-> ##[0:1] sda_oe_n_o == data_q[7])
        else $error("first read bit is not the msb");
    chk_queue_hold: assert property (wr_valid_o && !wr_ready_i |=>
        wr_valid_o && $stable(wr_addr_o) && $stable(wr_data_o)) else $error("queue head moved");
    chk_start_release: assert property ($fell(sda_i) && scl_i |=> sda_oe_n_o [*8])
        else $error("data driven right after start");
    chk_stop_release: assert property ($rose(sda_i) && scl_i |=> sda_oe_n_o [*8])
        else $error("data driven right after stop");

    cover property (rd_strobe_o);
    cover property (wr_valid_o && wr_ready_i);
    cover property (wr_valid_o && !wr_ready_i);
endmodule

bind i2crs_slave i2crs_slave_properties i2crs_slave_properties_inst (.*);
